// File: pde_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// External pins: driven pins show the drive, released pins the far level
module pde_pin_model (
  input wire logic [7:0] pd_out,
  input wire logic [7:0] pd_oe,
  input wire logic [7:0] pd_ext,
  input wire logic [2:0] pe_out,
  input wire logic [2:0] pe_oe,
  input wire logic [2:0] pe_ext,
  output logic [7:0] pd_in,
  output logic [2:0] pe_in
);
  assign pd_in = (pd_out & pd_oe) | (pd_ext & ~pd_oe);
  assign pe_in = (pe_out & pe_oe) | (pe_ext & ~pe_oe);
endmodule : pde_pin_model
`default_nettype wire

// File: pde_pkg.sv
// ==========================================================================
// Shared constants for the two general purpose ports
package pde_pkg;

  // ==========================================================================
  // Widths
  localparam int PD_W = 8;
  localparam int PE_W = 3;
  localparam int PIN_W = PD_W + PE_W;
  localparam int BANK_W = 4;

  // ==========================================================================
  // Register map, reached only in the ports bank
  localparam logic [BANK_W-1:0] BANK_PORTS = 4'h1;
  localparam logic [7:0] ADDR_PD_DIR = 8'h12;
  localparam logic [7:0] ADDR_PD_DATA = 8'h13;
  localparam logic [7:0] ADDR_PE_DIR = 8'h14;
  localparam logic [7:0] ADDR_PE_DATA = 8'h15;

  // ==========================================================================
  // Reset values
  localparam logic [PD_W-1:0] PD_DIR_RST = 8'hFF;
  localparam logic [PE_W-1:0] PE_DIR_RST = 3'h7;
  localparam logic [PD_W-1:0] PD_LAT_RST = 8'h00;
  localparam logic [PE_W-1:0] PE_LAT_RST = 3'h0;
  localparam logic [7:0] RDATA_RST = 8'h00;
  localparam logic [PIN_W-1:0] PIN_RST = 11'h000;

  // ==========================================================================
  // Strobe positions on the 3-bit port in bus mode
  localparam int PE_ALE_BIT = 0;
  localparam int PE_OE_BIT = 1;
  localparam int PE_WR_BIT = 2;

  // ==========================================================================
  // Processor memory modes from the configuration bits
  typedef enum logic [1:0] {
    MODE_MICROPROCESSOR = 2'h0,
    MODE_EXTENDED_MCU = 2'h1,
    MODE_MCU = 2'h2,
    MODE_PROTECTED_MCU = 2'h3
  } pde_mode_e;

endpackage : pde_pkg

// File: pde_ports.sv
`timescale 1ns/1ps
`default_nettype none

// Contract
// - An 8-bit bidirectional port, each pin usable as input or output.
// - Direction bit one makes the pin an input, driver off.
// - Direction bit zero makes the pin an output driven from its latch.
// - Reading a data register returns pin levels, not the latch.
// - Writing a data register loads the latch; reaches only output pins.
// - Microprocessor or extended modes make both ports the system bus; else GPIO.
// - In bus mode the 8-bit port carries the bus high byte.
// - A second 3-bit port with own direction register, same GPIO behaviour.
// - In bus mode 3-bit port bit0 latch strobe, bit1 read enable, bit2 write.
// - Read enable and write strobes on the 3-bit port are active low.
// - Unused upper bits of 3-bit port registers read zero, ignore writes.
module pde_ports (
  input wire logic mclk,
  input wire logic resetn,
  input wire pde_pkg::pde_mode_e cfg_mode,
  input wire logic [pde_pkg::BANK_W-1:0] bank_select,
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [pde_pkg::PD_W-1:0] bus_high_byte_out,
  input wire logic bus_high_byte_drive,
  input wire logic bus_ale,
  input wire logic bus_oe_n,
  input wire logic bus_wr_n,
  output logic [pde_pkg::PD_W-1:0] bus_high_byte_in,
  output logic bus_mode,
  input wire logic [pde_pkg::PD_W-1:0] pd_pin_in,
  output logic [pde_pkg::PD_W-1:0] pd_pin_out,
  output logic [pde_pkg::PD_W-1:0] pd_pin_oe,
  input wire logic [pde_pkg::PE_W-1:0] pe_pin_in,
  output logic [pde_pkg::PE_W-1:0] pe_pin_out,
  output logic [pde_pkg::PE_W-1:0] pe_pin_oe
);
  import pde_pkg::*;

  // ==========================================================================
  // Pin input synchronisers
  logic [PIN_W-1:0] sync1_r, sync2_r, sync3_r, pins_r;
  logic [PIN_W-1:0] sync1_nxt, sync2_nxt, sync3_nxt, pins_nxt;

  always_comb begin
    sync1_nxt = {pe_pin_in, pd_pin_in};
    sync2_nxt = sync1_r;
    sync3_nxt = sync2_r;
    // Accept a bit once second and third stages agree
    pins_nxt = (sync3_r & ~(sync2_r ^ sync3_r)) | (pins_r & (sync2_r ^ sync3_r));
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sync1_r <= PIN_RST;
      sync2_r <= PIN_RST;
      sync3_r <= PIN_RST;
      pins_r <= PIN_RST;
    end else begin
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
      sync3_r <= sync3_nxt;
      pins_r <= pins_nxt;
    end
  end

  // ==========================================================================
  // Register access decode
  logic bank_ok;
  logic wr_pd_dir, wr_pd_data, wr_pe_dir, wr_pe_data;
  logic rd_pd_dir, rd_pd_data, rd_pe_dir, rd_pe_data;

  always_comb begin
    bank_ok = (bank_select == BANK_PORTS);
    wr_pd_dir = reg_wr && bank_ok && (reg_addr == ADDR_PD_DIR);
    wr_pd_data = reg_wr && bank_ok && (reg_addr == ADDR_PD_DATA);
    wr_pe_dir = reg_wr && bank_ok && (reg_addr == ADDR_PE_DIR);
    wr_pe_data = reg_wr && bank_ok && (reg_addr == ADDR_PE_DATA);
    rd_pd_dir = reg_rd && bank_ok && (reg_addr == ADDR_PD_DIR);
    rd_pd_data = reg_rd && bank_ok && (reg_addr == ADDR_PD_DATA);
    rd_pe_dir = reg_rd && bank_ok && (reg_addr == ADDR_PE_DIR);
    rd_pe_data = reg_rd && bank_ok && (reg_addr == ADDR_PE_DATA);
  end

  // ==========================================================================
  // Direction registers and output latches
  logic [PD_W-1:0] pd_dir_r, pd_dir_nxt, pd_lat_r, pd_lat_nxt;
  logic [PE_W-1:0] pe_dir_r, pe_dir_nxt, pe_lat_r, pe_lat_nxt;
  logic [7:0] rdata_nxt;

  always_comb begin
    pd_dir_nxt = pd_dir_r;
    pd_lat_nxt = pd_lat_r;
    pe_dir_nxt = pe_dir_r;
    pe_lat_nxt = pe_lat_r;
    if (wr_pd_dir) begin
      pd_dir_nxt = reg_wdata;
    end
    if (wr_pd_data) begin
      pd_lat_nxt = reg_wdata;
    end
    if (wr_pe_dir) begin
      pe_dir_nxt = reg_wdata[PE_W-1:0];
    end
    if (wr_pe_data) begin
      pe_lat_nxt = reg_wdata[PE_W-1:0];
    end
    rdata_nxt = reg_rdata;
    if (reg_rd) begin
      rdata_nxt = 8'h00;
      unique case (1'h1)
        rd_pd_dir: rdata_nxt = pd_dir_r;
        rd_pd_data: rdata_nxt = pins_r[PD_W-1:0];
        rd_pe_dir: rdata_nxt = {5'h00, pe_dir_r};
        rd_pe_data: rdata_nxt = {5'h00, pins_r[PIN_W-1:PD_W]};
        default: rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      pd_dir_r <= PD_DIR_RST;
      pd_lat_r <= PD_LAT_RST;
      pe_dir_r <= PE_DIR_RST;
      pe_lat_r <= PE_LAT_RST;
      reg_rdata <= RDATA_RST;
    end else begin
      pd_dir_r <= pd_dir_nxt;
      pd_lat_r <= pd_lat_nxt;
      pe_dir_r <= pe_dir_nxt;
      pe_lat_r <= pe_lat_nxt;
      reg_rdata <= rdata_nxt;
    end
  end

  // ==========================================================================
  // Pin drive, GPIO or system bus
  logic bus_mode_nxt;
  logic [PD_W-1:0] pd_out_nxt, pd_oe_nxt, bus_in_nxt;
  logic [PE_W-1:0] pe_out_nxt, pe_oe_nxt;

  always_comb begin
    bus_mode_nxt = (cfg_mode == MODE_MICROPROCESSOR) || (cfg_mode == MODE_EXTENDED_MCU);
    bus_in_nxt = pins_r[PD_W-1:0];
    if (bus_mode) begin
      pd_out_nxt = bus_high_byte_out;
      pd_oe_nxt = {PD_W{bus_high_byte_drive}};
      pe_out_nxt[PE_ALE_BIT] = bus_ale;
      pe_out_nxt[PE_OE_BIT] = bus_oe_n;
      pe_out_nxt[PE_WR_BIT] = bus_wr_n;
      pe_oe_nxt = {PE_W{1'h1}};
    end else begin
      pd_out_nxt = pd_lat_r;
      pd_oe_nxt = ~pd_dir_r;
      pe_out_nxt = pe_lat_r;
      pe_oe_nxt = ~pe_dir_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      bus_mode <= 1'h0;
      bus_high_byte_in <= PD_LAT_RST;
      pd_pin_out <= PD_LAT_RST;
      pd_pin_oe <= 8'h00;
      pe_pin_out <= PE_LAT_RST;
      pe_pin_oe <= 3'h0;
    end else begin
      bus_mode <= bus_mode_nxt;
      bus_high_byte_in <= bus_in_nxt;
      pd_pin_out <= pd_out_nxt;
      pd_pin_oe <= pd_oe_nxt;
      pe_pin_out <= pe_out_nxt;
      pe_pin_oe <= pe_oe_nxt;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  property p_dir_input;
    !bus_mode |=> (pd_pin_oe & $past(pd_dir_r)) == 8'h00 && (pe_pin_oe & $past(pe_dir_r)) == 3'h0;
  endproperty
  a_dir_input: assert property (p_dir_input) else $error("input pin driven");

  property p_dir_output;
    !bus_mode |=> pd_pin_oe == ~$past(pd_dir_r) && pd_pin_out == $past(pd_lat_r);
  endproperty
  a_dir_output: assert property (p_dir_output) else $error("output pin not from latch");

  property p_read_pins;
    rd_pd_data |=> reg_rdata == $past(pins_r[PD_W-1:0]);
  endproperty
  a_read_pins: assert property (p_read_pins) else $error("data read not pin level");

  property p_write_latch;
    wr_pd_data && !bus_mode && !bus_mode_nxt ##1 !wr_pd_data |=> pd_pin_out == $past(reg_wdata, 2);
  endproperty
  a_write_latch: assert property (p_write_latch) else $error("latch write lost");

  property p_mode_select;
    ##1 bus_mode == ((($past(cfg_mode) == MODE_MICROPROCESSOR)) || ($past(cfg_mode) == MODE_EXTENDED_MCU));
  endproperty
  a_mode_select: assert property (p_mode_select) else $error("bus mode wrong");

  property p_bus_high;
    bus_mode |=> pd_pin_out == $past(bus_high_byte_out) && pd_pin_oe == {PD_W{$past(bus_high_byte_drive)}};
  endproperty
  a_bus_high: assert property (p_bus_high) else $error("high byte not on port");

  property p_pe_dir_write;
    wr_pe_dir |=> pe_dir_r == $past(reg_wdata[PE_W-1:0]);
  endproperty
  a_pe_dir_write: assert property (p_pe_dir_write) else $error("3-bit direction write lost");

  property p_strobes;
    bus_mode |=> pe_pin_oe == 3'h7 && pe_pin_out == {$past(bus_wr_n), $past(bus_oe_n), $past(bus_ale)};
  endproperty
  a_strobes: assert property (p_strobes) else $error("strobe mapping wrong");

  property p_oe_low;
    bus_mode && !bus_oe_n |=> pe_pin_out[PE_OE_BIT] == 1'h0 && pe_pin_oe[PE_OE_BIT] == 1'h1;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("read strobe not low");

  property p_wr_low;
    bus_mode && !bus_wr_n |=> pe_pin_out[PE_WR_BIT] == 1'h0 && pe_pin_oe[PE_WR_BIT] == 1'h1;
  endproperty
  a_wr_low: assert property (p_wr_low) else $error("write strobe not low");

  property p_pe_upper_zero;
    (rd_pe_dir || rd_pe_data) |=> reg_rdata[7:PE_W] == 5'h00;
  endproperty
  a_pe_upper_zero: assert property (p_pe_upper_zero) else $error("unused bits not zero");

  property p_bus_override;
    bus_mode && wr_pd_dir ##1 bus_mode |=> pd_pin_oe == {PD_W{$past(bus_high_byte_drive)}};
  endproperty
  a_bus_override: assert property (p_bus_override) else $error("direction leaked into bus");

  property p_bank_gate;
    reg_wr && !bank_ok |=> $stable(pd_dir_r) && $stable(pd_lat_r) && $stable(pe_dir_r) && $stable(pe_lat_r);
  endproperty
  a_bank_gate: assert property (p_bank_gate) else $error("write outside bank taken");

  property p_pd_dir_write;
    wr_pd_dir |=> pd_dir_r == $past(reg_wdata);
  endproperty
  a_pd_dir_write: assert property (p_pd_dir_write) else $error("8-bit direction write lost");

  property p_pd_lat_write;
    wr_pd_data |=> pd_lat_r == $past(reg_wdata);
  endproperty
  a_pd_lat_write: assert property (p_pd_lat_write) else $error("8-bit latch write lost");

  property p_pe_lat_write;
    wr_pe_data |=> pe_lat_r == $past(reg_wdata[PE_W-1:0]);
  endproperty
  a_pe_lat_write: assert property (p_pe_lat_write) else $error("3-bit latch write lost");

  property p_pe_gpio;
    !bus_mode |=> pe_pin_oe == ~$past(pe_dir_r) && pe_pin_out == $past(pe_lat_r);
  endproperty
  a_pe_gpio: assert property (p_pe_gpio) else $error("3-bit port not from latch");

  property p_read_pe_pins;
    rd_pe_data |=> reg_rdata == {5'h00, $past(pins_r[PIN_W-1:PD_W])};
  endproperty
  a_read_pe_pins: assert property (p_read_pe_pins) else $error("3-bit read not pin level");

  property p_rdata_hold;
    !reg_rd |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read");

  property p_unmapped_read;
    reg_rd && !(rd_pd_dir || rd_pd_data || rd_pe_dir || rd_pe_data) |=> reg_rdata == RDATA_RST;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("refused read not zero");

  property p_pin_hold;
    sync2_r != sync3_r |=> $stable(pins_r);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("unsettled pin accepted");

  property p_pin_accept;
    sync2_r == sync3_r |=> pins_r == $past(sync3_r);
  endproperty
  a_pin_accept: assert property (p_pin_accept) else $error("settled pin not accepted");

  property p_bus_in;
    ##1 bus_high_byte_in == $past(pins_r[PD_W-1:0]);
  endproperty
  a_bus_in: assert property (p_bus_in) else $error("high byte input not pin level");

  property p_pe_bus_drive;
    bus_mode && wr_pe_dir ##1 bus_mode |=> pe_pin_oe == 3'h7;
  endproperty
  a_pe_bus_drive: assert property (p_pe_bus_drive) else $error("direction leaked into strobes");

endmodule : pde_ports

`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pde_pkg::*;
  logic mclk = 0, resetn = 0, reg_wr = 0, reg_rd = 0;
  logic bus_drv = 0, bus_ale = 0, bus_oe_n = 1, bus_wr_n = 1, bus_mode;
  pde_mode_e cfg_mode = MODE_MCU;
  logic [3:0] bank_select = 4'h1;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, bus_out = 8'h00, bus_in;
  logic [7:0] pd_in, pd_out, pd_oe, pd_ext = 8'h3C;
  logic [2:0] pe_in, pe_out, pe_oe, pe_ext = 3'h2;
  int errors = 0, check_count = 0;
  always #5 mclk = ~mclk;
  pde_ports dut (.mclk(mclk), .resetn(resetn), .cfg_mode(cfg_mode), .bank_select(bank_select),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bus_high_byte_out(bus_out), .bus_high_byte_drive(bus_drv),
    .bus_ale(bus_ale), .bus_oe_n(bus_oe_n), .bus_wr_n(bus_wr_n), .bus_high_byte_in(bus_in),
    .bus_mode(bus_mode), .pd_pin_in(pd_in), .pd_pin_out(pd_out), .pd_pin_oe(pd_oe),
    .pe_pin_in(pe_in), .pe_pin_out(pe_out), .pe_pin_oe(pe_oe));
  pde_pin_model pins (.pd_out(pd_out), .pd_oe(pd_oe), .pd_ext(pd_ext), .pe_out(pe_out),
    .pe_oe(pe_oe), .pe_ext(pe_ext), .pd_in(pd_in), .pe_in(pe_in));
  // ==========================================================================
  // Shared tasks
  task automatic conclude;
    if (errors == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("Error %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask : w
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge mclk);
    reg_wr = 0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string m);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1;
    @(negedge mclk);
    reg_rd = 0;
    chk(reg_rdata, e, m);
  endtask : rd
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    rd(ADDR_PD_DIR, 8'hFF, "pd dir reset");
    rd(ADDR_PE_DIR, 8'h07, "pe dir reset");
    chk(pd_oe, 8'h00, "pd released");
    chk({5'h00, pe_oe}, 8'h00, "pe released");
  endtask : t_reset
  task automatic t_port_d;
    wr(ADDR_PD_DATA, 8'hA5);
    wr(ADDR_PD_DIR, 8'h0F);
    w(8);
    chk(pd_oe, 8'hF0, "pd oe");
    chk(pd_out & pd_oe, 8'hA0, "pd drive");
    rd(ADDR_PD_DATA, 8'hAC, "pd pins");
  endtask : t_port_d
  task automatic t_port_e;
    wr(ADDR_PE_DIR, 8'hFA);
    rd(ADDR_PE_DIR, 8'h02, "pe dir");
    wr(ADDR_PE_DATA, 8'hFD);
    w(8);
    chk({5'h00, pe_oe}, 8'h05, "pe oe");
    rd(ADDR_PE_DATA, 8'h07, "pe pins");
  endtask : t_port_e
  task automatic t_bank;
    bank_select = 4'h2;
    wr(ADDR_PD_DIR, 8'h00);
    rd(ADDR_PD_DIR, 8'h00, "other bank read");
    bank_select = 4'h1;
    rd(ADDR_PD_DIR, 8'h0F, "other bank write");
    rd(8'h16, 8'h00, "unmapped read");
  endtask : t_bank
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      @(negedge mclk);
      cfg_mode = pde_mode_e'(m);
      bus_drv = 1;
      bus_out = 8'h5A;
      bus_ale = 1;
      bus_oe_n = 0;
      w(3);
      chk({7'h00, bus_mode}, (m < 2) ? 8'h01 : 8'h00, "bus mode");
      chk(pd_oe, (m < 2) ? 8'hFF : 8'hF0, "pd oe mode");
      chk(pd_out & pd_oe, (m < 2) ? 8'h5A : 8'hA0, "pd mode");
      chk({5'h00, pe_oe}, (m < 2) ? 8'h07 : 8'h05, "pe oe mode");
      chk({5'h00, pe_out & pe_oe}, 8'h05, "strobes");
    end
    @(negedge mclk);
    cfg_mode = MODE_MICROPROCESSOR;
    bus_ale = 0;
    bus_oe_n = 1;
    bus_wr_n = 0;
    w(3);
    chk({5'h00, pe_out}, 8'h02, "write strobe low");
    bus_drv = 0;
    w(8);
    chk(pd_oe, 8'h00, "bus byte released");
    chk(bus_in, 8'h3C, "bus byte in");
    wr(ADDR_PD_DIR, 8'h00);
    wr(ADDR_PE_DIR, 8'h07);
    w(3);
    chk(pd_oe, 8'h00, "bus ignores direction");
    chk({5'h00, pe_oe}, 8'h07, "strobes still driven");
    rd(ADDR_PD_DIR, 8'h00, "direction stored in bus mode");
  endtask : t_modes
  // ==========================================================================
  // Main sequence and hang limit
  initial begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    resetn = 1;
    t_reset();
    t_port_d();
    t_port_e();
    t_bank();
    t_modes();
    conclude();
  end
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    conclude();
  end
endmodule : testbench
`default_nettype wire
